// File: hdl/i2c_coll_pkg.sv
// Constants and types shared by the collision-aware I2C master.
package i2c_coll_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0c;
  localparam logic [7:0] OFS_BUFFER = 8'h10;
  // Control register bit positions.
  localparam int CTL_EN = 0;
  localparam int CTL_START = 1;
  localparam int CTL_RSTART = 2;
  localparam int CTL_STOP = 3;
  localparam int CTL_ACK = 4;
  localparam int CTL_ACKDT = 5;
  localparam logic [5:0] CTL_SEQ_MASK = 6'h1e;
  // Status register bit positions.
  localparam int STAT_BF = 0;
  localparam int STAT_ACKSTAT = 1;
  localparam int STAT_START_SEEN = 3;
  localparam int STAT_STOP_SEEN = 4;
  localparam int STAT_SLEW = 7;
  // Flag register bit positions, write one to clear.
  localparam int FLG_COLL = 0;
  localparam int FLG_EVT = 1;
  // Values after reset.
  localparam logic [5:0] CTL_RST = 6'h00;
  localparam logic [7:0] RELOAD_RST = 8'h0a;
  // Bit counts within a byte.
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h00,
    ST_S1 = 5'h01,
    ST_S2 = 5'h02,
    ST_R1 = 5'h03,
    ST_R2 = 5'h04,
    ST_R3 = 5'h05,
    ST_R4 = 5'h06,
    ST_P1 = 5'h07,
    ST_P2 = 5'h08,
    ST_P3 = 5'h09,
    ST_P4 = 5'h0a,
    ST_A1 = 5'h0b,
    ST_A2 = 5'h0c,
    ST_A3 = 5'h0d,
    ST_T_LO = 5'h0e,
    ST_T_WAIT = 5'h0f,
    ST_T_HI = 5'h10
  } state_e;
endpackage

// File: hdl/i2c_master_collision_arbitration.sv
// I2C master sequencer with bus arbitration and an AXI4-Lite port.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// - Released one bit read back low with SCL high is a collision.
// - Collision in a byte halts shifting, clears buffer-full, frees lines.
// - Collision in a sequence aborts it and clears its sequence bit; enable stays set.
// - After a collision a bus STOP still sets the port event flag.
// - A buffer write after a collision restarts at the first bit.
// - Bus START and STOP detection both set the port event flag.
// - SDA or SCL low when START begins is a collision.
// - START releases both lines and loads the rate counter in the same cycle.
// - SCL low with SDA high in first START count is a collision.
// - SDA low in first START count reloads and drives SDA early.
// - Second START count drives SDA low, ignores SCL, then pulls SCL.
// - Repeated START checks SDA once SCL reads high after one count.
// - SCL falling with SDA released in second count is a collision.
// - Final Repeated START count ends by pulling SCL low.
// - STOP releases SDA at timeout; SDA low at the next timeout, or with SCL low, is a collision.
// - SCL low during STOP after it has read high, before SDA is released, is a collision.
// - Status slew bit selects slew limiting on the serial pins.
// - SDA rising while SCL high sets the stop-seen flag.
// - Reset disables the port and ends every sequence.
module i2c_master_collision_arbitration #(
  parameter int RELOAD_W = 7
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Serial bus pins
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  // Pin slew control and flags
  output logic slew_limit_out,
  output logic collision_flag_out,
  output logic port_event_flag_out
);
  if (RELOAD_W < 1 || RELOAD_W > 8)
  begin : g_chk
    $error("RELOAD_W must lie between 1 and 8");
  end

  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    i2c_coll_pkg::state_e st;
    logic [5:0] ctl;
    logic bf;
    logic ack_stat;
    logic start_seen;
    logic stop_seen;
    logic slew;
    logic coll;
    logic evt;
    logic [RELOAD_W-1:0] reload;
    logic [7:0] tbuf;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic sda_oe;
    logic scl_oe;
    logic sda_o;
    logic scl_o;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_s;

  regs_s r;
  regs_s n;
  logic brg_load;
  logic brg_zero;
  logic collide;
  logic tx_req;
  logic wr_go;
  logic bus_start;
  logic bus_stop;

  rate_counter #(
    .WIDTH(RELOAD_W)
  ) u_rate (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .load_in(brg_load),
    .reload_in(r.reload),
    .zero_out(brg_zero)
  );

  // Bus conditions compare the second synchroniser stage with its delayed copy.
  assign bus_start = r.scl_s2 & r.scl_p & r.sda_p & ~r.sda_s2;
  assign bus_stop = r.scl_s2 & r.scl_p & ~r.sda_p & r.sda_s2;

  always_comb
  begin
    n = r;
    brg_load = 1'b0;
    collide = 1'b0;
    tx_req = 1'b0;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;
    n.sda_p = r.sda_s2;
    n.scl_s1 = scl_in;
    n.scl_s2 = r.scl_s1;
    n.scl_p = r.scl_s2;
    // Write address and data are taken in either order.
    if (awvalid_in && r.awready)
    begin
      n.aw_have = 1'b1;
      n.awaddr = awaddr_in;
    end
    if (wvalid_in && r.wready)
    begin
      n.w_have = 1'b1;
      n.wdata = wdata_in[7:0];
      n.wstrb0 = wstrb_in[0];
    end
    if (r.bvalid && bready_in)
    begin
      n.bvalid = 1'b0;
    end
    wr_go = n.aw_have && n.w_have && !n.bvalid;
    if (wr_go)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = i2c_coll_pkg::RESP_OKAY;
      if (n.awaddr == i2c_coll_pkg::OFS_CTRL)
      begin
        if (n.wstrb0)
        begin
          n.ctl = n.wdata[5:0];
        end
      end
      else if (n.awaddr == i2c_coll_pkg::OFS_STATUS)
      begin
        if (n.wstrb0)
        begin
          n.slew = n.wdata[i2c_coll_pkg::STAT_SLEW];
        end
      end
      else if (n.awaddr == i2c_coll_pkg::OFS_FLAGS)
      begin
        if (n.wstrb0)
        begin
          n.coll = r.coll & ~n.wdata[i2c_coll_pkg::FLG_COLL];
          n.evt = r.evt & ~n.wdata[i2c_coll_pkg::FLG_EVT];
        end
      end
      else if (n.awaddr == i2c_coll_pkg::OFS_RELOAD)
      begin
        if (n.wstrb0)
        begin
          n.reload = n.wdata[RELOAD_W-1:0];
        end
      end
      else if (n.awaddr == i2c_coll_pkg::OFS_BUFFER)
      begin
        if (n.wstrb0 && r.st == i2c_coll_pkg::ST_IDLE && !r.bf &&
            r.ctl[i2c_coll_pkg::CTL_EN] &&
            (r.ctl & i2c_coll_pkg::CTL_SEQ_MASK) == 6'h00)
        begin
          n.tbuf = n.wdata;
          tx_req = 1'b1;
        end
      end
      else
      begin
        n.bresp = i2c_coll_pkg::RESP_SLVERR;
      end
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    if (r.rvalid && rready_in)
    begin
      n.rvalid = 1'b0;
    end
    if (arvalid_in && r.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = i2c_coll_pkg::RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if (araddr_in == i2c_coll_pkg::OFS_CTRL)
      begin
        n.rdata[5:0] = r.ctl;
      end
      else if (araddr_in == i2c_coll_pkg::OFS_STATUS)
      begin
        n.rdata[i2c_coll_pkg::STAT_BF] = r.bf;
        n.rdata[i2c_coll_pkg::STAT_ACKSTAT] = r.ack_stat;
        n.rdata[i2c_coll_pkg::STAT_START_SEEN] = r.start_seen;
        n.rdata[i2c_coll_pkg::STAT_STOP_SEEN] = r.stop_seen;
        n.rdata[i2c_coll_pkg::STAT_SLEW] = r.slew;
      end
      else if (araddr_in == i2c_coll_pkg::OFS_FLAGS)
      begin
        n.rdata[i2c_coll_pkg::FLG_COLL] = r.coll;
        n.rdata[i2c_coll_pkg::FLG_EVT] = r.evt;
      end
      else if (araddr_in == i2c_coll_pkg::OFS_RELOAD)
      begin
        n.rdata[RELOAD_W-1:0] = r.reload;
      end
      else if (araddr_in == i2c_coll_pkg::OFS_BUFFER)
      begin
        n.rdata[7:0] = r.tbuf;
      end
      else
      begin
        n.rresp = i2c_coll_pkg::RESP_SLVERR;
      end
    end
    n.arready = !n.rvalid;
    // Bus monitor keeps running in every state; the set wins over a clear.
    if (bus_start)
    begin
      n.start_seen = 1'b1;
      n.stop_seen = 1'b0;
      n.evt = 1'b1;
    end
    if (bus_stop)
    begin
      n.stop_seen = 1'b1;
      n.start_seen = 1'b0;
      n.evt = 1'b1;
    end
    case (r.st)
      i2c_coll_pkg::ST_IDLE:
      begin
        if (r.ctl[i2c_coll_pkg::CTL_START])
        begin
          if (!r.sda_s2 || !r.scl_s2)
          begin
            collide = 1'b1;
          end
          else
          begin
            n.sda_oe = 1'b0;
            n.scl_oe = 1'b0;
            brg_load = 1'b1;
            n.st = i2c_coll_pkg::ST_S1;
          end
        end
        else if (r.ctl[i2c_coll_pkg::CTL_RSTART])
        begin
          n.sda_oe = 1'b0;
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_R1;
        end
        else if (r.ctl[i2c_coll_pkg::CTL_STOP])
        begin
          n.sda_oe = 1'b1;
          n.st = i2c_coll_pkg::ST_P1;
        end
        else if (r.ctl[i2c_coll_pkg::CTL_ACK])
        begin
          n.scl_oe = 1'b1;
          n.sda_oe = !r.ctl[i2c_coll_pkg::CTL_ACKDT];
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_A1;
        end
        else if (tx_req)
        begin
          n.shift = n.tbuf;
          n.bitcnt = 4'h0;
          n.bf = 1'b1;
          n.scl_oe = 1'b1;
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_T_LO;
        end
      end
      i2c_coll_pkg::ST_S1:
      begin
        if (!r.scl_s2 && r.sda_s2)
        begin
          collide = 1'b1;
        end
        else if (!r.sda_s2 || brg_zero)
        begin
          n.sda_oe = 1'b1;
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_S2;
        end
      end
      i2c_coll_pkg::ST_S2:
      begin
        if (brg_zero)
        begin
          n.scl_oe = 1'b1;
          n.ctl[i2c_coll_pkg::CTL_START] = 1'b0;
          n.st = i2c_coll_pkg::ST_IDLE;
        end
      end
      i2c_coll_pkg::ST_R1:
      begin
        if (brg_zero)
        begin
          n.scl_oe = 1'b0;
          n.st = i2c_coll_pkg::ST_R2;
        end
      end
      i2c_coll_pkg::ST_R2:
      begin
        if (r.scl_s2 && !r.sda_s2)
        begin
          collide = 1'b1;
        end
        else if (r.scl_s2)
        begin
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_R3;
        end
      end
      i2c_coll_pkg::ST_R3:
      begin
        if (!r.scl_s2 && r.sda_s2)
        begin
          collide = 1'b1;
        end
        else if (brg_zero)
        begin
          n.sda_oe = 1'b1;
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_R4;
        end
      end
      i2c_coll_pkg::ST_R4:
      begin
        if (brg_zero)
        begin
          n.scl_oe = 1'b1;
          n.ctl[i2c_coll_pkg::CTL_RSTART] = 1'b0;
          n.st = i2c_coll_pkg::ST_IDLE;
        end
      end
      i2c_coll_pkg::ST_P1:
      begin
        if (!r.sda_s2)
        begin
          n.scl_oe = 1'b0;
          n.st = i2c_coll_pkg::ST_P2;
        end
      end
      i2c_coll_pkg::ST_P2:
      begin
        if (r.scl_s2)
        begin
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_P3;
        end
      end
      i2c_coll_pkg::ST_P3:
      begin
        if (!r.scl_s2)
        begin
          collide = 1'b1;
        end
        else if (brg_zero)
        begin
          n.sda_oe = 1'b0;
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_P4;
        end
      end
      i2c_coll_pkg::ST_P4:
      begin
        if ((!r.scl_s2 && !r.sda_s2) || (brg_zero && !r.sda_s2))
        begin
          collide = 1'b1;
        end
        else if (brg_zero)
        begin
          n.ctl[i2c_coll_pkg::CTL_STOP] = 1'b0;
          n.evt = 1'b1;
          n.st = i2c_coll_pkg::ST_IDLE;
        end
      end
      i2c_coll_pkg::ST_A1:
      begin
        if (brg_zero)
        begin
          n.scl_oe = 1'b0;
          n.st = i2c_coll_pkg::ST_A2;
        end
      end
      i2c_coll_pkg::ST_A2:
      begin
        if (r.scl_s2)
        begin
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_A3;
        end
      end
      i2c_coll_pkg::ST_A3:
      begin
        if (r.ctl[i2c_coll_pkg::CTL_ACKDT] && !r.sda_s2)
        begin
          collide = 1'b1;
        end
        else if (brg_zero)
        begin
          n.scl_oe = 1'b1;
          n.ctl[i2c_coll_pkg::CTL_ACK] = 1'b0;
          n.evt = 1'b1;
          n.st = i2c_coll_pkg::ST_IDLE;
        end
      end
      i2c_coll_pkg::ST_T_LO:
      begin
        n.sda_oe = !r.shift[7];
        if (brg_zero)
        begin
          n.scl_oe = 1'b0;
          n.st = i2c_coll_pkg::ST_T_WAIT;
        end
      end
      i2c_coll_pkg::ST_T_WAIT:
      begin
        if (r.scl_s2)
        begin
          brg_load = 1'b1;
          n.st = i2c_coll_pkg::ST_T_HI;
        end
      end
      i2c_coll_pkg::ST_T_HI:
      begin
        if (r.bitcnt != i2c_coll_pkg::BIT_ACK && r.shift[7] && !r.sda_s2)
        begin
          collide = 1'b1;
        end
        else if (brg_zero)
        begin
          n.scl_oe = 1'b1;
          brg_load = 1'b1;
          if (r.bitcnt == i2c_coll_pkg::BIT_ACK)
          begin
            n.ack_stat = r.sda_s2;
            n.evt = 1'b1;
            n.st = i2c_coll_pkg::ST_IDLE;
          end
          else
          begin
            n.shift = {r.shift[6:0], 1'b1};
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == i2c_coll_pkg::BIT_LAST)
            begin
              n.bf = 1'b0;
            end
            n.st = i2c_coll_pkg::ST_T_LO;
          end
        end
      end
      default:
      begin
        n.st = i2c_coll_pkg::ST_IDLE;
      end
    endcase
    if (collide || !n.ctl[i2c_coll_pkg::CTL_EN])
    begin
      n.coll = n.coll | collide;
      n.st = i2c_coll_pkg::ST_IDLE;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
      n.bf = 1'b0;
      n.ctl = n.ctl & ~i2c_coll_pkg::CTL_SEQ_MASK;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
      r.ctl <= i2c_coll_pkg::CTL_RST;
      r.reload <= i2c_coll_pkg::RELOAD_RST[RELOAD_W-1:0];
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_p <= 1'b1;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_p <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign awready_out = r.awready;
  assign wready_out = r.wready;
  assign bvalid_out = r.bvalid;
  assign bresp_out = r.bresp;
  assign arready_out = r.arready;
  assign rvalid_out = r.rvalid;
  assign rdata_out = r.rdata;
  assign rresp_out = r.rresp;
  // Pins only ever pull low; the enable alone decides the level.
  assign sda_out = r.sda_o;
  assign scl_out = r.scl_o;
  assign sda_oe_out = r.sda_oe;
  assign scl_oe_out = r.scl_oe;
  assign slew_limit_out = r.slew;
  assign collision_flag_out = r.coll;
  assign port_event_flag_out = r.evt;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_tx_arb;
    (r.st == i2c_coll_pkg::ST_T_HI && r.bitcnt != i2c_coll_pkg::BIT_ACK
      && r.shift[7] && !r.sda_s2) |=> (r.coll && r.st == i2c_coll_pkg::ST_IDLE);
  endproperty
  a_tx_arb: assert property (p_tx_arb) else $error("lost bit not flagged");
  property p_coll_release;
    $rose(r.coll) |-> (!r.sda_oe && !r.scl_oe && !r.bf);
  endproperty
  a_coll_release: assert property (p_coll_release) else $error("lines held");
  property p_coll_seq;
    $rose(r.coll) |-> ((r.ctl & i2c_coll_pkg::CTL_SEQ_MASK) == 6'h00);
  endproperty
  a_coll_seq: assert property (p_coll_seq) else $error("sequence kept");
  property p_stop_seen;
    bus_stop |=> (r.stop_seen && r.evt && !r.start_seen);
  endproperty
  a_stop_seen: assert property (p_stop_seen) else $error("stop missed");
  property p_start_seen;
    bus_start |=> (r.start_seen && r.evt);
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start missed");
  property p_tx_load;
    tx_req |=> (r.st == i2c_coll_pkg::ST_T_LO && r.bitcnt == 4'h0 && r.bf
      && r.shift == $past(n.tbuf));
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("byte not restarted");
  property p_start_busy;
    (r.st == i2c_coll_pkg::ST_IDLE && r.ctl[i2c_coll_pkg::CTL_START]
      && (!r.sda_s2 || !r.scl_s2)) |=> (r.coll && r.st == i2c_coll_pkg::ST_IDLE);
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy start");
  property p_start_scl;
    (r.st == i2c_coll_pkg::ST_S1 && !r.scl_s2 && r.sda_s2) |=> r.coll;
  endproperty
  a_start_scl: assert property (p_start_scl) else $error("start scl low");
  property p_start_end;
    (r.st == i2c_coll_pkg::ST_S2 && brg_zero && n.ctl[i2c_coll_pkg::CTL_EN])
      |=> (r.scl_oe && r.sda_oe && r.st == i2c_coll_pkg::ST_IDLE);
  endproperty
  a_start_end: assert property (p_start_end) else $error("start unfinished");
  property p_rs_sda;
    (r.st == i2c_coll_pkg::ST_R2 && r.scl_s2 && !r.sda_s2) |=> r.coll;
  endproperty
  a_rs_sda: assert property (p_rs_sda) else $error("rstart sda low");
  property p_stop_scl;
    (r.st == i2c_coll_pkg::ST_P3 && !r.scl_s2) |=> (r.coll && !r.scl_oe);
  endproperty
  a_stop_scl: assert property (p_stop_scl) else $error("stop scl low");
  property p_reset;
    disable iff (1'b0) !rst_n_in |=> (r.st == i2c_coll_pkg::ST_IDLE
      && !sda_oe_out && !scl_oe_out);
  endproperty
  a_reset: assert property (p_reset) else $error("reset ignored");
endmodule

// File: hdl/rate_counter.sv
// Down counter that times each phase of the serial clock.
`timescale 1ns/10ps
module rate_counter #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic load_in,
  input wire logic [WIDTH-1:0] reload_in,
  // Status
  output logic zero_out
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic zero;
  } cnt_s;

  cnt_s r;
  cnt_s n;

  always_comb
  begin
    n = r;
    if (load_in)
    begin
      n.count = reload_in;
    end
    else if (r.count != '0)
    begin
      n.count = r.count - 1'b1;
    end
    n.zero = (n.count == '0) && !load_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign zero_out = r.zero;
endmodule

// File: verification/bus_peer.sv
// Model of another master or slave sharing the open-drain bus.
`timescale 1ns/10ps
module bus_peer (
  // Commands from the bench
  input wire logic hold_sda_in,
  input wire logic hold_scl_in,
  input wire logic contend_in,
  // Bus line
  input wire logic scl_in,
  // Pull-downs, high while pulling the line low
  output logic sda_pull_out,
  output logic scl_pull_out
);
  // A contending master drives a zero whenever SCL is high.
  assign sda_pull_out = hold_sda_in | (contend_in & scl_in);
  assign scl_pull_out = hold_scl_in;
endmodule

// File: verification/tb.sv
// Self-checking bench for the collision-aware I2C master.
`timescale 1ns/10ps
module tb;
  logic clk_in, rst_n_in, awvalid_in, wvalid_in, arvalid_in;
  logic [7:0] awaddr_in, araddr_in;
  logic [31:0] wdata_in, rdata_out, v;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic [1:0] bresp_out, rresp_out, rs;
  logic sda_out, sda_oe_out, scl_out, scl_oe_out, slew_limit_out;
  logic collision_flag_out, port_event_flag_out;
  logic sda_w, scl_w, sda_pull, scl_pull, f_sda, f_scl, grab;
  logic [7:0] seq [3];
  int miscompares, comparisons, i, j;
  assign sda_w = ~(sda_oe_out | sda_pull);
  assign scl_w = ~(scl_oe_out | scl_pull);
  i2c_master_collision_arbitration u_i2c_master_collision_arbitration (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in), .awready_out(awready_out),
    .wdata_in(wdata_in), .wstrb_in(4'hf), .wvalid_in(wvalid_in),
    .wready_out(wready_out), .bresp_out(bresp_out),
    .bvalid_out(bvalid_out), .bready_in(1'b1), .araddr_in(araddr_in),
    .arvalid_in(arvalid_in), .arready_out(arready_out),
    .rdata_out(rdata_out), .rresp_out(rresp_out),
    .rvalid_out(rvalid_out), .rready_in(1'b1), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_out(scl_oe_out),
    .slew_limit_out(slew_limit_out),
    .collision_flag_out(collision_flag_out),
    .port_event_flag_out(port_event_flag_out));
  bus_peer u_bus_peer (.hold_sda_in(f_sda), .hold_scl_in(f_scl),
    .contend_in(grab), .scl_in(scl_w), .sda_pull_out(sda_pull),
    .scl_pull_out(scl_pull));
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task tmo();
    miscompares++;
    $display("wrong value wait expected done seen timeout");
    wrap_up();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr_in <= a;
    wdata_in <= d;
    awvalid_in <= 1'b1;
    wvalid_in <= 1'b1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge clk_in);
      if (awready_out)
        awvalid_in <= 1'b0;
      if (wready_out)
        wvalid_in <= 1'b0;
      if (bvalid_out)
        break;
    end
    rs = bresp_out;
    if (n == 99)
      tmo();
  endtask
  task rd(input logic [7:0] a);
    int n;
    araddr_in <= a;
    arvalid_in <= 1'b1;
    for (n = 0; n < 99; n++)
    begin
      @(posedge clk_in);
      if (arready_out)
        arvalid_in <= 1'b0;
      if (rvalid_out)
        break;
    end
    v = rdata_out;
    rs = rresp_out;
    if (n == 99)
      tmo();
  endtask
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    for (n = 0; n < 300; n++)
    begin
      rd(a);
      if ((v & m) === e)
        break;
    end
    if (n == 300)
      tmo();
  endtask
  task lines(input logic s, input logic c);
    chk("sda_oe", {31'h0, s}, {31'h0, sda_oe_out});
    chk("scl_oe", {31'h0, c}, {31'h0, scl_oe_out});
    chk("pin_low", 32'h0, {30'h0, sda_out, scl_out});
  endtask
  task start();
    wr(i2c_coll_pkg::OFS_CTRL, 32'h3);
    poll(i2c_coll_pkg::OFS_CTRL, 32'h2, 32'h0);
  endtask
  task settle();
    repeat (8) @(posedge clk_in);
    wr(i2c_coll_pkg::OFS_FLAGS, 32'h3);
  endtask
  initial
  begin
    {rst_n_in, awvalid_in, wvalid_in, arvalid_in, f_sda, f_scl, grab} = 0;
    {awaddr_in, araddr_in, wdata_in} = 0;
    seq = '{8'h05, 8'h09, 8'h31};
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(i2c_coll_pkg::OFS_CTRL);
    chk("ctrl", 32'h0, v);
    rd(i2c_coll_pkg::OFS_RELOAD);
    chk("reload", 32'h0a, v);
    lines(1'b0, 1'b0);
    rd(8'h14);
    chk("rresp", {30'h0, i2c_coll_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(8'h14, 32'h1);
    chk("bresp", {30'h0, i2c_coll_pkg::RESP_SLVERR}, {30'h0, rs});
    wr(i2c_coll_pkg::OFS_STATUS, 32'h80);
    rd(i2c_coll_pkg::OFS_STATUS);
    chk("slew", 32'h1, {31'h0, slew_limit_out});
    wr(i2c_coll_pkg::OFS_RELOAD, 32'h4);
    wr(i2c_coll_pkg::OFS_CTRL, 32'h1);
    $display("test registers done");
    f_sda <= 1'b1;
    repeat (8) @(posedge clk_in);
    wr(i2c_coll_pkg::OFS_CTRL, 32'h3);
    poll(i2c_coll_pkg::OFS_FLAGS, 32'h1, 32'h1);
    chk("coll_pin", 32'h1, {31'h0, collision_flag_out});
    rd(i2c_coll_pkg::OFS_CTRL);
    chk("seq_bits", 32'h0, v & 32'h1e);
    lines(1'b0, 1'b0);
    wr(i2c_coll_pkg::OFS_FLAGS, 32'h3);
    f_sda <= 1'b0;
    poll(i2c_coll_pkg::OFS_FLAGS, 32'h2, 32'h2);
    chk("evt_pin", 32'h1, {31'h0, port_event_flag_out});
    rd(i2c_coll_pkg::OFS_STATUS);
    chk("stop_seen", 32'h10, v & 32'h10);
    settle();
    $display("test start collision done");
    start();
    lines(1'b1, 1'b1);
    rd(i2c_coll_pkg::OFS_STATUS);
    chk("start_seen", 32'h08, v & 32'h08);
    rd(i2c_coll_pkg::OFS_FLAGS);
    chk("flags", 32'h2, v);
    wr(i2c_coll_pkg::OFS_FLAGS, 32'h3);
    grab <= 1'b1;
    wr(i2c_coll_pkg::OFS_BUFFER, 32'hff);
    poll(i2c_coll_pkg::OFS_FLAGS, 32'h1, 32'h1);
    rd(i2c_coll_pkg::OFS_STATUS);
    chk("buffer_full", 32'h0, v & 32'h1);
    lines(1'b0, 1'b0);
    grab <= 1'b0;
    settle();
    wr(i2c_coll_pkg::OFS_BUFFER, 32'h7f);
    for (i = 0; i < 40 && sda_oe_out !== 1'b1; i++)
      @(posedge clk_in);
    chk("first_bit", 32'h1, {31'h0, sda_oe_out});
    wr(i2c_coll_pkg::OFS_CTRL, 32'h0);
    wr(i2c_coll_pkg::OFS_CTRL, 32'h1);
    settle();
    $display("test byte collision done");
    for (i = 0; i < 3; i++)
    begin
      start();
      wr(i2c_coll_pkg::OFS_FLAGS, 32'h3);
      grab <= (i != 1);
      wr(i2c_coll_pkg::OFS_CTRL, {24'h0, seq[i]});
      // The peer grabs SCL only after the stop has seen it high.
      for (j = 0; j < 40 && i == 1 && scl_oe_out !== 1'b0; j++)
        @(posedge clk_in);
      repeat (2) @(posedge clk_in);
      f_scl <= (i == 1);
      poll(i2c_coll_pkg::OFS_FLAGS, 32'h1, 32'h1);
      rd(i2c_coll_pkg::OFS_CTRL);
      chk("seq_bits", 32'h0, v & 32'h1e);
      lines(1'b0, 1'b0);
      grab <= 1'b0;
      f_scl <= 1'b0;
      settle();
    end
    $display("test sequence collisions done");
    wr(i2c_coll_pkg::OFS_CTRL, 32'h3);
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    lines(1'b0, 1'b0);
    rd(i2c_coll_pkg::OFS_CTRL);
    chk("ctrl", 32'h0, v);
    $display("test reset done");
    wrap_up();
  end
endmodule
